// file: logic/dtm_ctrl.sv
// Test-mode control: mode register, NAND tree, scan control, PLL test.
`timescale 1ns/1ps
`include "dtm_defines.svh"

module dtm_ctrl (
  // Clock, reset, enable.
  input  wire logic                clk_sys_i,
  input  wire logic                sys_rst_i,
  input  wire logic                clk_en_i,
  // Asynchronous pins.
  input  wire dtm_pkg::dtm_pins_t  pins_i,
  // Core-side signals on this clock.
  input  wire logic [109:0]        func_oe_i,
  input  wire logic [5:0]          scan_tail_i,
  // Test mode status.
  output logic [7:0]               test_code_o,
  output dtm_pkg::dtm_mode_t       test_mode_sel_o,
  output logic [109:0]             pad_oe_o,
  output logic                     nand_out_o,
  output logic                     nand_out_oe_o,
  // Scan control.
  output dtm_pkg::dtm_scan_t       scan_ctrl_o,
  output logic [5:0]               scan_head_o,
  output logic [5:0]               scan_out_o,
  output logic                     scan_out_oe_o,
  // PLL test.
  output logic                     vco_bypass_o,
  output logic [11:0]              vco_cnt_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  dtm_pkg::dtm_pins_t pin_s1_q;
  dtm_pkg::dtm_pins_t pin_q;

  // Two flops per pin; only pin_q is read by logic.
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      pin_s1_q <= '0;
      pin_q    <= '0;
    end
    else if (clk_en_i)
    begin
      pin_s1_q <= pins_i;
      pin_q    <= pin_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial load of the test mode register.

  logic                     strobe_old_q;
  logic [7:0]               shreg_q;
  logic [7:0]               shreg_d;
  logic [2:0]               bitcnt_q;
  logic [7:0]               code_q;
  logic                     strobe_rise;
  logic                     load_last;

  // A rising strobe shifts one bit, MSB first.
  assign strobe_rise = pin_q.test_load_strobe & ~strobe_old_q;
  assign shreg_d     = {shreg_q[6:0], pin_q.test_load_data};
  assign load_last   = strobe_rise & (bitcnt_q == `DTM_BITCNT_LAST);

  // The code is applied whole, so partial shifts never show as a mode.
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      strobe_old_q <= 1'b0;
      shreg_q      <= `DTM_CODE_RST;
      bitcnt_q     <= '0;
      code_q       <= `DTM_CODE_RST;
    end
    else if (clk_en_i)
    begin
      strobe_old_q <= pin_q.test_load_strobe;
      if (pin_q.bus_rst)
      begin
        shreg_q  <= `DTM_CODE_RST;
        bitcnt_q <= '0;
        code_q   <= `DTM_CODE_RST;
      end
      else if (strobe_rise)
      begin
        shreg_q  <= shreg_d;
        bitcnt_q <= bitcnt_q + 3'h1;
        if (load_last)
          code_q <= shreg_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode.

  dtm_pkg::dtm_mode_t mode_d;
  logic               nand_d;

  // Only three codes mean anything; the rest is normal mode.
  assign mode_d = (code_q == `DTM_CODE_SIM0) ? dtm_pkg::dtm_sim0 :
                  (code_q == `DTM_CODE_SIM1) ? dtm_pkg::dtm_sim1 :
                  (code_q == `DTM_CODE_NAND) ? dtm_pkg::dtm_nand :
                  dtm_pkg::dtm_normal;
  assign nand_d = (mode_d == dtm_pkg::dtm_nand);

  ////////////////////////////////////////////////////////////////////////////
  // NAND tree, first pin at index 0, memory chip select at index 109.

  logic [109:0] nand_stage;

  assign nand_stage[0] = pin_q.nand_pins[0];
  generate
    for (genvar i = 1; i < `DTM_NAND_LEN; i++)
    begin : g_nand
      assign nand_stage[i] = ~(nand_stage[i-1] & pin_q.nand_pins[i]);
    end
  endgenerate

  // Mode outputs; in NAND mode pad enables are killed so every pad listens; the NAND output drives, and the scan output too if the scan pins are set.
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      test_code_o     <= `DTM_CODE_RST;
      test_mode_sel_o <= dtm_pkg::dtm_normal;
      pad_oe_o        <= '0;
      nand_out_o      <= 1'b0;
      nand_out_oe_o   <= 1'b0;
    end
    else if (clk_en_i)
    begin
      test_code_o     <= code_q;
      test_mode_sel_o <= mode_d;
      pad_oe_o        <= nand_d ? '0 : func_oe_i;
      nand_out_o      <= nand_d & nand_stage[`DTM_NAND_LEN-1];
      nand_out_oe_o   <= nand_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan control.

  logic scan_d;

  // The grant pin is low active in function but must sit high here.
  assign scan_d = pin_q.test_mode & pin_q.register_window_enable_pin &
                  pin_q.bus_grant_n;

  // Clock muxing itself sits in the clock tree; we drive its selects.
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      scan_ctrl_o   <= '0;
      scan_head_o   <= '0;
      scan_out_o    <= '0;
      scan_out_oe_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      scan_ctrl_o.scan_mode  <= scan_d;
      scan_ctrl_o.latch_open <= scan_d;
      scan_ctrl_o.shift_en   <= scan_d & pin_q.shift_sel;
      scan_ctrl_o.clk_sel_bus               <= scan_d;
      scan_ctrl_o.disk_ch0_domain_clock_sel <= scan_d;
      scan_ctrl_o.disk_ch1_domain_clock_sel <= scan_d;
      scan_ctrl_o.scan_clk <= scan_d ? {pin_q.ch1_cable_detect_pin,
                                        pin_q.ch0_cable_detect_pin,
                                        pin_q.bus_clk_pin} : 3'h0;
      scan_head_o   <= scan_d ? pin_q.scan_in : 6'h00;
      scan_out_o    <= scan_d ? scan_tail_i : 6'h00;
      scan_out_oe_o <= scan_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PLL test: bypass select and VCO divider.

  logic vco_old_q;
  logic vco_rise;

  assign vco_rise = pin_q.vco_clk & ~vco_old_q;

  // The counter's MSB toggles once per 2048 VCO edges: period 4096.
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      vco_old_q    <= 1'b0;
      vco_cnt_o    <= '0;
      vco_bypass_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      vco_old_q    <= pin_q.vco_clk;
      vco_bypass_o <= pin_q.vco_bypass_force_pin;
      if (vco_rise)
        vco_cnt_o <= vco_cnt_o + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  property p_bus_rst_clear;
    clk_en_i && pin_q.bus_rst |=> code_q == `DTM_CODE_RST ##1
      (!$past(clk_en_i) || test_mode_sel_o == dtm_pkg::dtm_normal);
  endproperty
  a_bus_rst_clear: assert property (p_bus_rst_clear)
    else $error("bus reset did not clear the test mode");

  property p_unlisted;
    clk_en_i && code_q != `DTM_CODE_SIM0 && code_q != `DTM_CODE_SIM1 &&
      code_q != `DTM_CODE_NAND |=> test_mode_sel_o == dtm_pkg::dtm_normal;
  endproperty
  a_unlisted: assert property (p_unlisted)
    else $error("unlisted code left normal mode");

  property p_sim_decode;
    clk_en_i && code_q == `DTM_CODE_SIM1 |=>
      test_mode_sel_o == dtm_pkg::dtm_sim1;
  endproperty
  a_sim_decode: assert property (p_sim_decode)
    else $error("code A1 not decoded as sim mode one");

  property p_nand_inputs;
    test_mode_sel_o == dtm_pkg::dtm_nand |-> pad_oe_o == '0 && nand_out_oe_o;
  endproperty
  a_nand_inputs: assert property (p_nand_inputs)
    else $error("pad driven in NAND mode");

  property p_nand_out;
    clk_en_i && nand_d |=> nand_out_o == $past(nand_stage[109]);
  endproperty
  a_nand_out: assert property (p_nand_out)
    else $error("NAND output does not follow chain end");

  property p_scan_mode;
    clk_en_i |=> scan_ctrl_o.scan_mode == $past(scan_d) &&
      scan_ctrl_o.latch_open == scan_ctrl_o.scan_mode;
  endproperty
  a_scan_mode: assert property (p_scan_mode)
    else $error("scan mode does not follow the three pins");

  property p_shift_en;
    scan_ctrl_o.shift_en |-> scan_ctrl_o.scan_mode;
  endproperty
  a_shift_en: assert property (p_shift_en)
    else $error("shift enable outside scan mode");

  property p_scan_out;
    clk_en_i && scan_d |=> scan_out_o == $past(scan_tail_i) && scan_out_oe_o;
  endproperty
  a_scan_out: assert property (p_scan_out)
    else $error("scan output not driven from chain tail");

  property p_bypass;
    clk_en_i |=> vco_bypass_o == $past(pin_q.vco_bypass_force_pin);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("VCO bypass does not follow its pin");

  property p_vco_wrap;
    clk_en_i && vco_rise && vco_cnt_o == `DTM_VCO_CNT_LAST |=> vco_cnt_o == '0;
  endproperty
  a_vco_wrap: assert property (p_vco_wrap)
    else $error("VCO divider does not wrap at 4096");

  sequence s_last_bit;
    clk_en_i && load_last && !pin_q.bus_rst;
  endsequence
  property p_load_apply;
    s_last_bit |=> code_q == $past(shreg_d) && bitcnt_q == '0;
  endproperty
  a_load_apply: assert property (p_load_apply)
    else $error("eighth bit did not apply the code");

endmodule : dtm_ctrl

// file: shared/dtm_defines.svh
// Constants for the test-mode control block: codes, widths, reset values.
`ifndef DTM_DEFINES_SVH
`define DTM_DEFINES_SVH

`define DTM_CODE_W       8
`define DTM_CODE_RST     8'h00
`define DTM_CODE_SIM0    8'hA0
`define DTM_CODE_SIM1    8'hA1
`define DTM_CODE_NAND    8'hAA
`define DTM_BITCNT_W     3
`define DTM_BITCNT_LAST  3'h7
`define DTM_NAND_LEN     110
`define DTM_SCAN_CHAINS  6
`define DTM_VCO_DIV      4096
`define DTM_VCO_CNT_W    12
`define DTM_VCO_CNT_LAST 12'hFFF

`endif

// file: shared/dtm_pkg.sv
// Types shared by the test-mode control block.
package dtm_pkg;

  // Decoded test mode; anything unlisted falls back to normal operation.
  typedef enum logic [1:0] {
    dtm_normal,
    dtm_sim0,
    dtm_sim1,
    dtm_nand
  } dtm_mode_t;

  // All asynchronous pin inputs, synchronised together.
  typedef struct packed {
    logic [109:0] nand_pins;
    logic         test_load_data;
    logic         test_load_strobe;
    logic         bus_rst;
    logic         test_mode;
    logic         register_window_enable_pin;
    logic         bus_grant_n;
    logic         shift_sel;
    logic [5:0]   scan_in;
    logic         bus_clk_pin;
    logic         ch0_cable_detect_pin;
    logic         ch1_cable_detect_pin;
    logic         vco_bypass_force_pin;
    logic         vco_clk;
  } dtm_pins_t;

  // Scan control outputs towards the core.
  typedef struct packed {
    logic       scan_mode;
    logic       latch_open;
    logic       shift_en;
    logic       clk_sel_bus;
    logic       disk_ch0_domain_clock_sel;
    logic       disk_ch1_domain_clock_sel;
    logic [2:0] scan_clk;
  } dtm_scan_t;

endpackage : dtm_pkg

// file: test/dtm_tester.sv
// Tester model that drives the test pins of the block.
`timescale 1ns/1ps
module dtm_tester (
  // Clock.
  input  wire logic          clk_sys_i,
  // Pins towards the block.
  output dtm_pkg::dtm_pins_t pins_o
);
  dtm_pkg::dtm_pins_t pins_q = '0;
  assign pins_o = pins_q;

  ////////////////////////////////////////////////////////////////////
  // Shifts n bits MSB first; each strobe phase is held well past the
  // two cycles the block's synchroniser needs.
  task automatic load_bits(input logic [7:0] v, input int n);
    for (int i = 7; i > 7 - n; i--)
    begin
      pins_q.test_load_data = v[i];
      repeat (2) @(negedge clk_sys_i);
      pins_q.test_load_strobe = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      pins_q.test_load_strobe = 1'b0;
      repeat (4) @(negedge clk_sys_i);
    end
    // Data is stale after the frame, so it is flipped.
    pins_q.test_load_data = ~pins_q.test_load_data;
  endtask : load_bits

  // Host bus reset pulse, long enough to pass the synchroniser.
  task automatic bus_reset();
    pins_q.bus_rst = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    pins_q.bus_rst = 1'b0;
    repeat (4) @(negedge clk_sys_i);
  endtask : bus_reset

  // Slow oscillator, six system cycles a period.
  task automatic vco_run(input int n);
    repeat (n)
    begin
      pins_q.vco_clk = 1'b1;
      repeat (3) @(negedge clk_sys_i);
      pins_q.vco_clk = 1'b0;
      repeat (3) @(negedge clk_sys_i);
    end
  endtask : vco_run
endmodule : dtm_tester

// file: test/tb_dtm_ctrl.sv
// Self-checking bench for the test-mode control block.
`timescale 1ns/1ps
`include "dtm_defines.svh"
module tb_dtm_ctrl;
  typedef struct packed {
    logic [34:0]  obs;
    logic [109:0] oe;
  } dtm_note_t;

  logic               clk_sys_i = 1'b0;
  logic               sys_rst_i = 1'b1;
  logic               clk_en_i = 1'b1;
  logic [109:0]       func_oe_i = '0;
  logic [5:0]         scan_tail_i = '0;
  dtm_pkg::dtm_pins_t pins;
  logic [7:0]         test_code_o;
  dtm_pkg::dtm_mode_t mode_o;
  logic [109:0]       pad_oe_o;
  logic               nand_out_o;
  logic               nand_oe_o;
  dtm_pkg::dtm_scan_t scan_o;
  logic [5:0]         head_o;
  logic [5:0]         sout_o;
  logic               sout_oe_o;
  logic               byp_o;
  logic [11:0]        vco_cnt_o;
  logic [7:0]         exp_code = 8'h00;
  int unsigned        bad_count = 0;
  int unsigned        n_compared = 0;
  int unsigned        cycles = 0;
  dtm_note_t          notes[$];
  event               chk_ev;
  logic [7:0]         codes[7] = '{8'hA0, 8'hA1, 8'hAA, 8'hA2, 8'hAB,
                                   8'h2A, 8'hFF};
  wire [34:0] obs_w = {test_code_o, mode_o, nand_out_o, nand_oe_o,
                       scan_o, head_o, sout_o, sout_oe_o, byp_o};

  always #2 clk_sys_i = ~clk_sys_i;

  dtm_tester tester_u (.clk_sys_i(clk_sys_i), .pins_o(pins));

  dtm_ctrl dut_u (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .pins_i(pins), .func_oe_i(func_oe_i), .scan_tail_i(scan_tail_i),
    .test_code_o(test_code_o), .test_mode_sel_o(mode_o),
    .pad_oe_o(pad_oe_o), .nand_out_o(nand_out_o),
    .nand_out_oe_o(nand_oe_o), .scan_ctrl_o(scan_o),
    .scan_head_o(head_o), .scan_out_o(sout_o),
    .scan_out_oe_o(sout_oe_o), .vco_bypass_o(byp_o),
    .vco_cnt_o(vco_cnt_o));

  ////////////////////////////////////////////////////////////////////
  // Expected outputs worked out from the pins as driven now.
  function automatic dtm_note_t expect_now();
    dtm_pkg::dtm_mode_t m;
    logic               s;
    logic               n;
    logic               t;
    dtm_note_t          r;
    m = dtm_pkg::dtm_normal;
    if (exp_code == `DTM_CODE_SIM0) m = dtm_pkg::dtm_sim0;
    if (exp_code == `DTM_CODE_SIM1) m = dtm_pkg::dtm_sim1;
    if (exp_code == `DTM_CODE_NAND) m = dtm_pkg::dtm_nand;
    t = (m == dtm_pkg::dtm_nand);
    s = pins.test_mode & pins.register_window_enable_pin
        & pins.bus_grant_n;
    n = pins.nand_pins[0];
    for (int i = 1; i < `DTM_NAND_LEN; i++)
      n = ~(n & pins.nand_pins[i]);
    r.obs = {exp_code, m, n & t, t, {4{s}} & {1'b1, 1'b1,
             pins.shift_sel, 1'b1}, s, s, {3{s}} & {pins.ch1_cable_detect_pin,
             pins.ch0_cable_detect_pin, pins.bus_clk_pin},
             {6{s}} & pins.scan_in, {6{s}} & scan_tail_i, s,
             pins.vco_bypass_force_pin};
    r.oe = t ? '0 : func_oe_i;
    return r;
  endfunction : expect_now

  // Notes the expectation, lets the pin paths settle, then checks.
  task automatic note();
    notes.push_back(expect_now());
    repeat (8) @(negedge clk_sys_i);
    -> chk_ev;
  endtask : note

  // Watcher: takes the oldest note off the queue and compares.
  always @(chk_ev)
  begin
    dtm_note_t e;
    e = notes.pop_front();
    n_compared += 2;
    if (e.obs !== obs_w)
    begin
      bad_count++;
      $display("Error outputs expected %h seen %h", e.obs, obs_w);
    end
    if (e.oe !== pad_oe_o)
    begin
      bad_count++;
      $display("Error pad_oe expected %h seen %h", e.oe, pad_oe_o);
    end
  end

  task automatic print_verdict();
    $display("Compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // Cuts a hang short well beyond the expected run length.
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'hF0DDC0FA));
    repeat (4) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    note();
    foreach (codes[k])
    begin
      func_oe_i = 110'({$urandom(), $urandom(), $urandom(), $urandom()});
      tester_u.pins_q.nand_pins = 110'({$urandom(), $urandom(),
                                        $urandom(), $urandom()});
      tester_u.load_bits(codes[k], 8);
      exp_code = codes[k];
      note();
      tester_u.pins_q.nand_pins = '1;
      note();
      tester_u.pins_q.nand_pins[`DTM_NAND_LEN - 1] = 1'b0;
      note();
    end
    tester_u.load_bits(8'hA1, 4);
    tester_u.bus_reset();
    exp_code = `DTM_CODE_RST;
    note();
    tester_u.load_bits(8'hA1, 8);
    exp_code = `DTM_CODE_SIM1;
    note();
    for (int k = 0; k < 16; k++)
    begin
      {tester_u.pins_q.test_mode, tester_u.pins_q.register_window_enable_pin,
       tester_u.pins_q.bus_grant_n} = k > 7 ? 3'h7 : 3'(k);
      tester_u.pins_q.shift_sel = 1'($urandom());
      tester_u.pins_q.scan_in = 6'($urandom());
      {tester_u.pins_q.ch1_cable_detect_pin,
       tester_u.pins_q.ch0_cable_detect_pin,
       tester_u.pins_q.bus_clk_pin} = 3'($urandom());
      tester_u.pins_q.vco_bypass_force_pin = 1'($urandom());
      scan_tail_i = 6'($urandom());
      note();
    end
    // With the enable low a moving pin must leave every output frozen.
    clk_en_i = 1'b0;
    notes.push_back(expect_now());
    tester_u.pins_q.vco_bypass_force_pin =
      ~tester_u.pins_q.vco_bypass_force_pin;
    repeat (8) @(negedge clk_sys_i);
    -> chk_ev;
    clk_en_i = 1'b1;
    tester_u.vco_run(4100);
    repeat (8) @(negedge clk_sys_i);
    n_compared++;
    if (vco_cnt_o !== 12'h004)
    begin
      bad_count++;
      $display("Error vco_cnt expected 004 seen %h", vco_cnt_o);
    end
    print_verdict();
  end
endmodule : tb_dtm_ctrl
